//--- hdl/csic_ctrl.sv
// Behaviour
// - ctrl bit7 selects ring indicate on shared pin
// - ctrl bit6 drives card reset, 0 asserts on memory cards only
// - ctrl bit5 records card type memory/io
// - diag 0: bit4 routes status change to pci
// - diag 1: bit4 ignored for routing
// - select 0000 means pci, ORed with bit4
// - nonzero select steers io irq, 0010 is smi
// - disabled source flag reads zero
// - enabled source sets flag, raises interrupt
// - clear by read or write one, global bit2
// - flag bits 7..4 read zero
// - bit3 set on card detect change
// - bit2 latches ready rise, memory only
// - bit1 latches battery warning, memory only
// - bit0 flags battery dead via status signal
// - ring enabled: bit0 latches ring input rise
// - context bits keep through pci reset if pme
// - diag 0, select 0000: pci regardless of bit4
// - ready flag interrupts only when enabled
`timescale 1ns/1ps
`include "csic_defines.svh"
module csic_ctrl
  import csic_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          pci_bus_reset_input,
  input  wire logic [11:0]   addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr_stb,
  input  wire logic          rd_stb,
  output logic      [7:0]    rdata,
  input  csic_card_in_t      card_in,
  input  wire logic          card_irq_req,
  output logic               card_reset_n,
  output logic               ring_indicate_enable,
  output csic_route_t        status_irq,
  output csic_route_t        card_irq
);

  // rst is the global reset; pci reset spares context bits while pme is on
  localparam int NFLAG = 4;

  // software visible registers
  logic [7:0]       ctrl_r;
  logic [7:0]       ctrl_nxt;
  logic [7:0]       cfg_r;
  logic [7:0]       cfg_nxt;
  logic [7:0]       global_r;
  logic [7:0]       global_nxt;
  logic [7:0]       diag_r;
  logic [7:0]       diag_nxt;
  logic [3:0]       flag_r;
  logic [3:0]       flag_nxt;

  // last sampled pin levels, for edge detection
  logic             det_one_r;
  logic             det_two_r;
  logic             ready_r;
  logic             warn_r;
  logic             dead_r;

  // next values of the registered outputs
  logic [7:0]       rdata_nxt;
  logic             card_reset_n_nxt;
  csic_route_t      status_nxt;
  csic_route_t      card_nxt;

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // a legacy code names one line; the smi code has no line of its own
  function automatic csic_route_t route_of(input logic [3:0] code, input logic req);
    csic_route_t r;
    r = '0;
    if (code == `CSIC_SEL_SMI) begin
      r.system_management_interrupt = req;
    end else if (code != `CSIC_SEL_NONE) begin
      r.irq_lines[code] = req;
    end
    return r;
  endfunction

  // address decode
  wire              sel_ctrl   = is_reg(addr, `CSIC_OFF_CTRL);
  wire              sel_flags  = is_reg(addr, `CSIC_OFF_FLAGS);
  wire              sel_cfg    = is_reg(addr, `CSIC_OFF_CFG);
  wire              sel_global = is_reg(addr, `CSIC_OFF_GLOBAL);
  wire              sel_diag   = is_reg(addr, `CSIC_OFF_DIAG);

  // one strobe per register action
  wire              wr_ctrl    = wr_stb && sel_ctrl;
  wire              wr_flags   = wr_stb && sel_flags;
  wire              wr_cfg     = wr_stb && sel_cfg;
  wire              wr_global  = wr_stb && sel_global;
  wire              wr_diag    = wr_stb && sel_diag;
  wire              rd_flags   = rd_stb && sel_flags;

  // reset qualification
  wire              pme_en     = global_r[`CSIC_GLB_PME_EN];
  wire              pci_clear  = pci_bus_reset_input;
  wire              ctx_clear  = pci_clear && !pme_en;

  // control fields
  wire              ring_on    = ctrl_r[`CSIC_CTRL_RING];
  wire              rst_off    = ctrl_r[`CSIC_CTRL_RESET];
  wire              io_card    = ctrl_r[`CSIC_CTRL_KIND];
  wire              pci_route  = ctrl_r[`CSIC_CTRL_ROUTE];
  wire [3:0]        fsel       = ctrl_r[`CSIC_CTRL_SEL_LSB +: 4];

  // configuration fields
  wire [3:0]        csel       = cfg_r[`CSIC_CFG_SEL_LSB +: 4];
  wire [3:0]        src_en;
  assign src_en[`CSIC_FLG_DET]  = cfg_r[`CSIC_CFG_DET_EN];
  assign src_en[`CSIC_FLG_RDY]  = cfg_r[`CSIC_CFG_RDY_EN];
  assign src_en[`CSIC_FLG_WARN] = cfg_r[`CSIC_CFG_WARN_EN];
  assign src_en[`CSIC_FLG_DEAD] = cfg_r[`CSIC_CFG_DEAD_EN];

  // global and diagnostic fields
  wire              clr_wr1    = global_r[`CSIC_GLB_CLR_WR1];
  wire              diag_route = diag_r[`CSIC_DIAG_ROUTE];

  // pin levels as seen this cycle
  wire              ready_now  = card_in.ready;
  // battery warning: bvd two high with bvd one low; dead comes from the status signal
  wire              warn_now   = card_in.battery_detect_two && !card_in.battery_detect_one;
  // shared pin: the ring input stands in for the status signal
  wire              dead_now   = ring_on ? card_in.battery_detect_one
                                         : card_in.card_status_change_signal;

  // one event per flag
  wire              det_chg    = (det_one_r != card_in.card_detect_one) ||
                                 (det_two_r != card_in.card_detect_two);
  wire              rdy_rise   = ready_now && !ready_r && !io_card;
  wire              warn_rise  = warn_now && !warn_r && !io_card;
  wire              dead_rise  = dead_now && !dead_r;
  wire [3:0]        events;
  assign events[`CSIC_FLG_DET]  = det_chg;
  assign events[`CSIC_FLG_RDY]  = rdy_rise;
  assign events[`CSIC_FLG_WARN] = warn_rise;
  assign events[`CSIC_FLG_DEAD] = dead_rise;

  // clear requests; only one method is live at a time
  wire [3:0]        clr_rd     = (rd_flags && !clr_wr1) ? 4'hf : 4'h0;
  wire [3:0]        clr_wr     = (wr_flags && clr_wr1) ? wdata[3:0] : 4'h0;
  wire [3:0]        clr_any    = clr_rd | clr_wr;

  // one slice per flag; set wins over a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      wire hold_b = flag_r[gi] && !clr_any[gi];
      wire next_b = hold_b || events[gi];
      assign flag_nxt[gi] = next_b && src_en[gi];
    end
  endgenerate

  // a disabled source reads as zero and never interrupts
  wire [3:0]        flag_rd    = flag_r & src_en;
  wire              any_flag   = |flag_rd;

  // legacy selection applies only when no pci route is in force
  wire              via_cfg    = (csel == `CSIC_SEL_NONE);
  wire              via_ctrl   = pci_route || (fsel == `CSIC_SEL_NONE);
  wire              csc_to_pci = diag_route ? via_cfg
                                            : via_ctrl;
  wire [3:0]        csc_code   = csc_to_pci ? `CSIC_SEL_NONE : csel;
  wire              card_req   = card_irq_req && io_card;

  always_comb begin
    status_nxt         = route_of(csc_code, any_flag);
    status_nxt.pci_int = csc_to_pci && any_flag;
  end

  assign card_nxt = route_of(fsel, card_req);

  // unmapped addresses read as zero
  wire [7:0]        flag_view  = {4'h0, flag_rd};
  logic [7:0]       rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr)
      `CSIC_OFF_CTRL: begin
        rd_mux = ctrl_r;
      end
      `CSIC_OFF_FLAGS: begin
        rd_mux = flag_view;
      end
      `CSIC_OFF_CFG: begin
        rd_mux = cfg_r;
      end
      `CSIC_OFF_GLOBAL: begin
        rd_mux = global_r;
      end
      `CSIC_OFF_DIAG: begin
        rd_mux = diag_r;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  assign rdata_nxt        = rd_stb ? rd_mux : 8'h00;
  // the reset bit only holds memory cards; io cards always run
  assign card_reset_n_nxt = rst_off || io_card;

  // a bus write beats a pci reset in the same cycle
  always_comb begin
    if (wr_ctrl) begin
      ctrl_nxt = wdata;
    end else if (ctx_clear) begin
      ctrl_nxt = `CSIC_CTRL_RST;
    end else if (pci_clear) begin
      ctrl_nxt = ctrl_r & `CSIC_CTRL_CTX;
    end else begin
      ctrl_nxt = ctrl_r;
    end
  end

  always_comb begin
    if (wr_cfg) begin
      cfg_nxt = wdata;
    end else if (ctx_clear) begin
      cfg_nxt = `CSIC_CFG_RST;
    end else if (pci_clear) begin
      cfg_nxt = cfg_r & `CSIC_CFG_CTX;
    end else begin
      cfg_nxt = cfg_r;
    end
  end

  // pci reset beats a bus write here
  always_comb begin
    if (pci_clear) begin
      global_nxt = global_r & `CSIC_GLOBAL_CTX;
    end else if (wr_global) begin
      global_nxt = wdata;
    end else begin
      global_nxt = global_r;
    end
  end

  always_comb begin
    if (pci_clear) begin
      diag_nxt = `CSIC_DIAG_RST;
    end else if (wr_diag) begin
      diag_nxt = wdata;
    end else begin
      diag_nxt = diag_r;
    end
  end

  // context registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `CSIC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= `CSIC_CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_r <= `CSIC_FLAG_RST;
    end else begin
      flag_r <= ctx_clear ? `CSIC_FLAG_RST : flag_nxt;
    end
  end

  // other registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      global_r <= `CSIC_GLOBAL_RST;
    end else begin
      global_r <= global_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      diag_r <= `CSIC_DIAG_RST;
    end else begin
      diag_r <= diag_nxt;
    end
  end

  // pin history
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      det_one_r <= 1'b0;
    end else begin
      det_one_r <= card_in.card_detect_one;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      det_two_r <= 1'b0;
    end else begin
      det_two_r <= card_in.card_detect_two;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ready_now;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      warn_r <= 1'b0;
    end else begin
      warn_r <= warn_now;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dead_r <= 1'b0;
    end else begin
      dead_r <= dead_now;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      card_reset_n <= 1'b0;
    end else begin
      card_reset_n <= card_reset_n_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ring_indicate_enable <= 1'b0;
    end else begin
      ring_indicate_enable <= ring_on;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_irq <= '0;
    end else begin
      status_irq <= status_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      card_irq <= '0;
    end else begin
      card_irq <= card_nxt;
    end
  end

endmodule

//--- hdl/csic_defines.svh
`ifndef CSIC_DEFINES_SVH
`define CSIC_DEFINES_SVH

// register offsets (byte addresses on the plain port)
`define CSIC_OFF_CTRL      12'h803
`define CSIC_OFF_FLAGS     12'h804
`define CSIC_OFF_CFG       12'h805
`define CSIC_OFF_GLOBAL    12'h81e
`define CSIC_OFF_DIAG      12'h893

// interrupt and general control fields
`define CSIC_CTRL_RING     7
`define CSIC_CTRL_RESET    6
`define CSIC_CTRL_KIND     5
`define CSIC_CTRL_ROUTE    4
`define CSIC_CTRL_SEL_LSB  0

// status-change configuration fields
`define CSIC_CFG_SEL_LSB   4
`define CSIC_CFG_DET_EN    3
`define CSIC_CFG_RDY_EN    2
`define CSIC_CFG_WARN_EN   1
`define CSIC_CFG_DEAD_EN   0

// flag positions
`define CSIC_FLG_DET       3
`define CSIC_FLG_RDY       2
`define CSIC_FLG_WARN      1
`define CSIC_FLG_DEAD      0

// global control: clear mode, power-management enable
`define CSIC_GLB_CLR_WR1   2
`define CSIC_GLB_PME_EN    0
// diagnostic: status-change routing control
`define CSIC_DIAG_ROUTE    5

// reset values and select codes
`define CSIC_CTRL_RST      8'h00
`define CSIC_CFG_RST       8'h00
`define CSIC_GLOBAL_RST    8'h00
`define CSIC_DIAG_RST      8'h20
`define CSIC_SEL_NONE      4'h0
`define CSIC_SEL_SMI       4'h2
`define CSIC_FLAG_RST      4'h0

// bits kept through a pci reset while pme is on
`define CSIC_CTRL_CTX      8'h60
`define CSIC_CFG_CTX       8'h0f
`define CSIC_GLOBAL_CTX    8'h01

`endif

//--- hdl/csic_pkg.sv
package csic_pkg;
  typedef struct packed {
    logic       card_detect_one;
    logic       card_detect_two;
    logic       ready;
    logic       battery_detect_one;
    logic       battery_detect_two;
    logic       card_status_change_signal;
  } csic_card_in_t;

  typedef struct packed {
    logic        pci_int;
    logic        system_management_interrupt;
    logic [15:0] irq_lines;
  } csic_route_t;
endpackage

//--- tb/csic_card.sv
`timescale 1ns/1ps
module csic_card
  import csic_pkg::*;
#(
  parameter int RDY_DLY = 4
)
(
  input  wire logic    sys_clk,
  input  wire logic    card_reset_n,
  output csic_card_in_t card_in,
  output logic         card_irq_req
);
  logic [5:0] pins = 6'b000110;
  logic [3:0] cnt  = 4'h0;
  initial card_irq_req = 1'b0;
  // busy while held in reset, so ready rises only after release
  always @(posedge sys_clk)
    cnt <= !card_reset_n ? 4'h0 : cnt + 4'(cnt != RDY_DLY);
  assign card_in = {pins[5:4], cnt == RDY_DLY, pins[2:0]};
endmodule

//--- tb/csic_ctrl_chk.sv
`timescale 1ns/1ps
module csic_ctrl_chk
  import csic_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        pci_bus_reset_input,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [7:0]  rdata,
  input wire logic        card_irq_req,
  input wire logic        card_reset_n,
  input wire logic        ring_indicate_enable,
  input csic_route_t      status_irq,
  input csic_route_t      card_irq
);
  default clocking @(posedge sys_clk); endclocking
  // bus reset rewrites control, so those relations pause meanwhile
  default disable iff (rst || pci_bus_reset_input);
  wire wc = wr_stb && addr == 12'h803;
  a_flags_hi_zero: assert property (rd_stb && addr == 12'h804 |=> rdata[7:4] == 4'h0)
    else $error("flag upper bits set");
  a_ring_follow: assert property (wc ##2 1 |-> ring_indicate_enable == $past(wdata[7], 2))
    else $error("ring enable wrong");
  a_reset_drive: assert property (wc ##2 1 |-> card_reset_n == ($past(wdata[6], 2)
    | $past(wdata[5], 2))) else $error("card reset wrong");
  a_ctrl_readback: assert property (wc ##2 (rd_stb && addr == 12'h803)
    |=> rdata == $past(wdata, 3)) else $error("control readback wrong");
  a_pci_clears_ring: assert property (disable iff (rst) pci_bus_reset_input
    |-> ##2 !ring_indicate_enable) else $error("ring enable kept");
  a_one_dest: assert property ($onehot0(status_irq))
    else $error("status routed twice");
  a_card_no_pci: assert property (!card_irq.pci_int && $onehot0(card_irq))
    else $error("card route wrong");
  a_card_idle: assert property (!card_irq_req [*3] |-> card_irq == '0)
    else $error("card irq without request");
  c_pci: cover property (status_irq.pci_int);
  c_smi: cover property (card_irq.system_management_interrupt);
  c_flag: cover property (rd_stb && addr == 12'h804 ##1 rdata != 8'h00);
endmodule
bind csic_ctrl csic_ctrl_chk u_chk (.*);

//--- tb/tb_csic_ctrl.sv
`timescale 1ns/1ps
module tb_csic_ctrl;
  import csic_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, pci_bus_reset_input = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, rdata;
  logic card_reset_n, ring_indicate_enable, card_irq_req;
  csic_card_in_t card_in;
  csic_route_t status_irq, card_irq;
  int errors = 0, samples_checked = 0, cyc = 0;
  csic_ctrl u_dut (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .pci_bus_reset_input  (pci_bus_reset_input),
    .addr                 (addr),
    .wdata                (wdata),
    .wr_stb               (wr_stb),
    .rd_stb               (rd_stb),
    .rdata                (rdata),
    .card_in              (card_in),
    .card_irq_req         (card_irq_req),
    .card_reset_n         (card_reset_n),
    .ring_indicate_enable (ring_indicate_enable),
    .status_irq           (status_irq),
    .card_irq             (card_irq)
  );
  csic_card u_card (
    .sys_clk      (sys_clk),
    .card_reset_n (card_reset_n),
    .card_in      (card_in),
    .card_irq_req (card_irq_req)
  );
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic [17:0] g, e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    chk({10'h000, rdata}, {10'h000, e});
    @(posedge sys_clk);
  endtask
  task automatic look(input bit c, input logic [17:0] e);
    @(negedge sys_clk);
    chk(c ? card_irq : status_irq, e);
    @(posedge sys_clk);
  endtask
  task automatic pins(input logic [5:0] p, input int n);
    u_card.pins <= p;
    repeat (n) @(posedge sys_clk);
  endtask
  task t_ready;
    wr(12'h803, 8'h00);
    wr(12'h805, 8'h04);
    pins(6'b000110, 8);
    rd(12'h804, 8'h00);
    wr(12'h803, 8'h40);
    pins(6'b000110, 8);
    look(0, 18'h20000);
    rd(12'h804, 8'h04);
    rd(12'h804, 8'h00);
    look(0, 18'h00000);
  endtask
  task t_detect;
    logic [23:0] rt [6] = '{24'h205038, 24'h204108, 24'h005038, 24'h004038,
                            24'h004138, 24'h004108};
    logic [17:0] re [6] = '{18'h8, 18'h20000, 18'h20000, 18'h20000, 18'h8, 18'h0};
    pins(6'b100110, 4);
    rd(12'h804, 8'h00);
    wr(12'h81e, 8'h04);
    wr(12'h805, 8'h38);
    pins(6'b000110, 4);
    rd(12'h804, 8'h08);
    rd(12'h804, 8'h08);
    foreach (rt[i]) begin
      wr(12'h893, rt[i][23:16]);
      wr(12'h803, rt[i][15:8]);
      wr(12'h805, rt[i][7:0]);
      look(0, re[i]);
    end
    wr(12'h804, 8'h08);
    rd(12'h804, 8'h00);
  endtask
  task t_io;
    logic [3:0] sl [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h9};
    wr(12'h805, 8'h02);
    wr(12'h803, 8'h60);
    pins(6'b000010, 4);
    rd(12'h804, 8'h00);
    u_card.card_irq_req <= 1'b1;
    foreach (sl[i]) begin
      wr(12'h803, {4'h6, sl[i]});
      look(1, sl[i] == 4'h2 ? 18'h10000 : 18'(1) << sl[i]);
    end
    u_card.card_irq_req <= 1'b0;
  endtask
  task t_dead;
    wr(12'h803, 8'h40);
    wr(12'h805, 8'h01);
    pins(6'b000111, 4);
    rd(12'h804, 8'h01);
    wr(12'h804, 8'h01);
    wr(12'h803, 8'hc0);
    pins(6'b000011, 2);
    pins(6'b000111, 4);
    rd(12'h804, 8'h01);
  endtask
  task t_pci_bus_reset_input;
    for (int p = 1; p >= 0; p--) begin
      wr(12'h81e, 8'(p));
      wr(12'h803, 8'hf0);
      pci_bus_reset_input <= 1'b1;
      @(posedge sys_clk);
      pci_bus_reset_input <= 1'b0;
      @(posedge sys_clk);
      rd(12'h803, p ? 8'h60 : 8'h00);
    end
  endtask
  task results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(12'h893, 8'h20);
    rd(12'h800, 8'h00);
    wr(12'h803, 8'h2f);
    rd(12'h803, 8'h2f);
    t_ready();
    t_detect();
    t_io();
    t_dead();
    t_pci_bus_reset_input();
    results();
  end
endmodule
